// ==== inc/fwcs_defines.vh ====
// Constants for the flash write control and status block.
`ifndef FWCS_DEFINES_VH
`define FWCS_DEFINES_VH
`define FWCS_ADDR_CTRL_LOW 24'h0E0000
`define FWCS_ADDR_CTRL_HIGH 24'h0E0002
`define FWCS_ADDR_EVEN_LOW 24'h0E0008
`define FWCS_ADDR_EVEN_HIGH 24'h0E000A
`define FWCS_ADDR_ODD_LOW 24'h0E000C
`define FWCS_ADDR_ODD_HIGH 24'h0E000E
`define FWCS_ADDR_PROG_LOW 24'h0E0010
`define FWCS_ADDR_PROG_HIGH 24'h0E0012
`define FWCS_ADDR_ERROR 24'h0E0014
`define FWCS_RESET_WORD 16'h0000
`define FWCS_INVALID_DATA 16'hFFFF
`define FWCS_TRAP_CODE 16'h009B
`define FWCS_BIT_BANK1 6
`define FWCS_BIT_BANK0 5
`define FWCS_BIT_LOCK 4
`define FWCS_BIT_BANK3 2
`define FWCS_BIT_BANK2 1
`define FWCS_BIT_START 15
`define FWCS_BIT_SUSPEND_REQUEST 14
`define FWCS_BIT_WPG 13
`define FWCS_BIT_DOUBLE_WORD_PROGRAM_SELECT 12
`define FWCS_BIT_SER 11
`define FWCS_BIT_SPR 8
`define FWCS_BIT_MODULE_SELECT 7
`define FWCS_BIT_ERR 0
`define FWCS_BIT_SEQUENCE_ERROR_FLAG 1
`define FWCS_BIT_WPROT 2
`define FWCS_PROT_LOW 24'h0EDFB0
`define FWCS_PROT_HIGH 24'h0EDFBF
`define FWCS_TEST_END 24'h002000
`define FWCS_BANK1_BASE 24'h070000
`define FWCS_BANK2_BASE 24'h090000
`define FWCS_BANK3_BASE 24'h0C0000
`define FWCS_FLASH_END 24'h0E0000
`define FWCS_MAIN_BANKS 4'h3
`define FWCS_SECOND_BANKS 4'hC
`define FWCS_PROT_BANKS 4'h4
`endif

// ==== verilog/fwcs_addr_check.v ====
// Address decoder giving bank, test sector and protection range hits.
`timescale 1ns/1ps
`include "fwcs_defines.vh"
module fwcs_addr_check (
  input wire [23:0] addr,
  output reg [3:0] bankHit,
  output wire testSector,
  output wire protRangeOk
);
  always @* begin
    bankHit = 4'h0;
    if (addr < `FWCS_BANK1_BASE) begin
      bankHit = 4'h1;
    end else if (addr < `FWCS_BANK2_BASE) begin
      bankHit = 4'h2;
    end else if (addr < `FWCS_BANK3_BASE) begin
      bankHit = 4'h4;
    end else if (addr < `FWCS_FLASH_END) begin
      bankHit = 4'h8;
    end
  end

  assign testSector = (addr < `FWCS_TEST_END);
  assign protRangeOk = (addr >= `FWCS_PROT_LOW) && (addr <= `FWCS_PROT_HIGH);
endmodule // fwcs_addr_check

// ==== verilog/fwcs_flash_write_ctrl.v ====
// Flash write control and status registers with bank busy and lock logic.
// Behaviour
// (R1) Each bank of the 16-bit module has a busy flag set on write start.
// (R2) Each bank of the 32-bit module has a busy flag set on write start.
// (R3) Set protection raises the busy flag of bank two.
// (R4) Busy bank reads give invalid data and trap; writes to it are ignored.
// (R5) End or suspend clears busy and frees the bank; resume sets it again.
// (R6) Lock set: control high, data, address, error reads trap; writes are ignored except a suspend request.
// (R7) Lock is set when software sets the write start bit.
// (R8) Lock stays readable always; software polls it low before other access.
// (R9) Error register readable and writable when unlocked, updated by hardware on completion; a refused start also sets its flags here.
// (R10) Module select zero targets the 16-bit module, one the 32-bit module.
// (R11) Module select clears when the write operation completes.
// (R12) Software sets protection select, address, even data, then start.
// (R13) Set protection outside the protection range flags a sequence error.
// (R14) Protection select clears when set protection finishes.
// (R15) Test sector writes refused; its reads valid only in bootstrap mode.
// (R16) Start bit starts an operation, clears on end or suspend, not by software.
// (R17) No second write operation is accepted while one is running.
// (R18) Completion updates errors and clears lock, busy and selects together.
`timescale 1ns/1ps
`include "fwcs_defines.vh"
module fwcs_flash_write_ctrl (
  input wire sys_clk,
  input wire rst_b,
  input wire [23:0] busAddr,
  input wire busRdEn,
  input wire busWrEn,
  input wire [1:0] busByteEn,
  input wire [15:0] busWrData,
  output reg [15:0] busRdData_ff,
  output reg busRdValid_ff,
  output reg busTrap_ff,
  output wire [15:0] busTrapCode,
  input wire bootstrapMode,
  input wire [23:0] memAddr,
  input wire memRdEn,
  input wire memWrEn,
  output wire memWrBlock,
  output reg memRdInvalid_ff,
  output reg opStart_ff,
  output reg opResume_ff,
  output reg opSuspendReq_ff,
  output reg [3:0] opKind_ff,
  output reg opModule_ff,
  output wire [23:0] opAddr,
  output wire [63:0] opData,
  input wire opDone,
  input wire opSuspended,
  input wire [15:0] opErrBits
);
  reg [3:0] busy_ff;
  reg [3:0] heldBanks_ff;
  reg lock_ff;
  reg startBit_ff;
  reg suspended_ff;
  reg [15:0] dataWord_ff [0:3];
  reg [15:0] addrLow_ff;
  reg [15:0] addrHigh_ff;
  reg [15:0] errReg_ff;
  reg [15:0] ctrlHigh;
  reg [15:0] ctrlLow;
  reg [15:0] nxt_ctrlHigh;
  reg [3:0] nxt_kind;
  reg [3:0] opBanks;
  wire [3:0] opBankHit;
  wire [3:0] memBankHit;
  wire opTestSector;
  wire memTestSector;
  wire opProtOk;
  wire lockedRegHit;
  wire memRdBad;
  integer i;

  function [15:0] mergeBytes;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0] be;
    begin
      mergeBytes = {be[1] ? newVal[15:8] : oldVal[15:8], be[0] ? newVal[7:0] : oldVal[7:0]};
    end
  endfunction

  assign opAddr = {addrHigh_ff[7:0], addrLow_ff};
  assign opData = {dataWord_ff[3], dataWord_ff[2], dataWord_ff[1], dataWord_ff[0]};
  assign busTrapCode = `FWCS_TRAP_CODE;

  fwcs_addr_check opCheck (
    .addr(opAddr),
    .bankHit(opBankHit),
    .testSector(opTestSector),
    .protRangeOk(opProtOk)
  );

  fwcs_addr_check memCheck (
    .addr(memAddr),
    .bankHit(memBankHit),
    .testSector(memTestSector),
    .protRangeOk()
  );

  always @* begin
    ctrlLow = `FWCS_RESET_WORD;
    ctrlLow[`FWCS_BIT_BANK0] = busy_ff[0]; // R2
    ctrlLow[`FWCS_BIT_BANK1] = busy_ff[1]; // R2
    ctrlLow[`FWCS_BIT_BANK2] = busy_ff[2]; // R1
    ctrlLow[`FWCS_BIT_BANK3] = busy_ff[3]; // R1
    ctrlLow[`FWCS_BIT_LOCK] = lock_ff;
    ctrlHigh = `FWCS_RESET_WORD;
    ctrlHigh[`FWCS_BIT_START] = startBit_ff;
    ctrlHigh[`FWCS_BIT_SUSPEND_REQUEST] = opSuspendReq_ff;
    ctrlHigh[`FWCS_BIT_WPG] = opKind_ff[3];
    ctrlHigh[`FWCS_BIT_DOUBLE_WORD_PROGRAM_SELECT] = opKind_ff[2];
    ctrlHigh[`FWCS_BIT_SER] = opKind_ff[1];
    ctrlHigh[`FWCS_BIT_SPR] = opKind_ff[0];
    ctrlHigh[`FWCS_BIT_MODULE_SELECT] = opModule_ff;
    nxt_ctrlHigh = mergeBytes(ctrlHigh, busWrData, busByteEn);
    nxt_kind = {nxt_ctrlHigh[`FWCS_BIT_WPG], nxt_ctrlHigh[`FWCS_BIT_DOUBLE_WORD_PROGRAM_SELECT],
      nxt_ctrlHigh[`FWCS_BIT_SER], nxt_ctrlHigh[`FWCS_BIT_SPR]};
    if (nxt_kind[0]) begin
      opBanks = `FWCS_PROT_BANKS; // R3
    end else if (nxt_ctrlHigh[`FWCS_BIT_MODULE_SELECT]) begin
      opBanks = opBankHit & `FWCS_MAIN_BANKS; // R10
    end else begin
      opBanks = opBankHit & `FWCS_SECOND_BANKS; // R10
    end
  end

  // Every register but the low control word is hidden while locked.
  assign lockedRegHit = lock_ff && (busAddr >= `FWCS_ADDR_CTRL_HIGH) &&
    (busAddr <= `FWCS_ADDR_ERROR); // R6
  assign memRdBad = ((memBankHit & busy_ff) != 4'h0) ||
    (memTestSector && !bootstrapMode); // R4 R15
  assign memWrBlock = memWrEn && ((memBankHit & busy_ff) != 4'h0); // R4

  // Register reads are answered one cycle after the strobe.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busRdData_ff <= `FWCS_RESET_WORD;
      busRdValid_ff <= 1'b0;
      busTrap_ff <= 1'b0;
      memRdInvalid_ff <= 1'b0;
    end else begin
      busRdValid_ff <= busRdEn;
      memRdInvalid_ff <= memRdEn && memRdBad; // R4
      busTrap_ff <= (busRdEn && lockedRegHit) || (memRdEn && memRdBad); // R4 R6
      if (busRdEn) begin
        if (lockedRegHit) begin
          busRdData_ff <= `FWCS_INVALID_DATA; // R6
        end else begin
          case (busAddr)
            `FWCS_ADDR_CTRL_LOW: busRdData_ff <= ctrlLow; // R8
            `FWCS_ADDR_CTRL_HIGH: busRdData_ff <= ctrlHigh;
            `FWCS_ADDR_EVEN_LOW: busRdData_ff <= dataWord_ff[0];
            `FWCS_ADDR_EVEN_HIGH: busRdData_ff <= dataWord_ff[1];
            `FWCS_ADDR_ODD_LOW: busRdData_ff <= dataWord_ff[2];
            `FWCS_ADDR_ODD_HIGH: busRdData_ff <= dataWord_ff[3];
            `FWCS_ADDR_PROG_LOW: busRdData_ff <= addrLow_ff;
            `FWCS_ADDR_PROG_HIGH: busRdData_ff <= addrHigh_ff;
            `FWCS_ADDR_ERROR: busRdData_ff <= errReg_ff; // R9
            default: busRdData_ff <= `FWCS_RESET_WORD;
          endcase
        end
      end
    end
  end

  // Operation control, start checks, suspend, resume and completion.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 4'h0;
      heldBanks_ff <= 4'h0;
      lock_ff <= 1'b0;
      startBit_ff <= 1'b0;
      suspended_ff <= 1'b0;
      opStart_ff <= 1'b0;
      opResume_ff <= 1'b0;
      opSuspendReq_ff <= 1'b0;
      opKind_ff <= 4'h0;
      opModule_ff <= 1'b0;
      addrLow_ff <= `FWCS_RESET_WORD;
      addrHigh_ff <= `FWCS_RESET_WORD;
      errReg_ff <= `FWCS_RESET_WORD;
      for (i = 0; i < 4; i = i + 1) begin
        dataWord_ff[i] <= `FWCS_RESET_WORD;
      end
    end else begin
      opStart_ff <= 1'b0;
      opResume_ff <= 1'b0;
      if (opDone) begin
        errReg_ff <= errReg_ff | opErrBits; // R9 R18
        if (opErrBits != `FWCS_RESET_WORD) begin
          errReg_ff[`FWCS_BIT_ERR] <= 1'b1;
        end
        busy_ff <= 4'h0; // R5 R18
        lock_ff <= 1'b0; // R18
        startBit_ff <= 1'b0; // R16
        suspended_ff <= 1'b0;
        opSuspendReq_ff <= 1'b0;
        opKind_ff <= 4'h0; // R14 R18
        opModule_ff <= 1'b0; // R11
      end else if (opSuspended) begin
        busy_ff <= 4'h0; // R5
        lock_ff <= 1'b0;
        startBit_ff <= 1'b0; // R16
        suspended_ff <= 1'b1;
      end else if (busWrEn) begin
        if (busAddr == `FWCS_ADDR_CTRL_HIGH) begin
          if (lock_ff) begin
            if (busByteEn[1] && busWrData[`FWCS_BIT_SUSPEND_REQUEST]) begin
              opSuspendReq_ff <= 1'b1;
            end
          end else if (suspended_ff) begin
            opSuspendReq_ff <= nxt_ctrlHigh[`FWCS_BIT_SUSPEND_REQUEST];
            if (nxt_ctrlHigh[`FWCS_BIT_START] && !nxt_ctrlHigh[`FWCS_BIT_SUSPEND_REQUEST] &&
                ((nxt_kind & opKind_ff) != 4'h0)) begin
              busy_ff <= heldBanks_ff; // R5
              lock_ff <= 1'b1; // R7
              startBit_ff <= 1'b1;
              suspended_ff <= 1'b0;
              opResume_ff <= 1'b1;
            end
          end else begin
            opSuspendReq_ff <= nxt_ctrlHigh[`FWCS_BIT_SUSPEND_REQUEST];
            opKind_ff <= nxt_kind;
            opModule_ff <= nxt_ctrlHigh[`FWCS_BIT_MODULE_SELECT];
            if (nxt_ctrlHigh[`FWCS_BIT_START] && !nxt_ctrlHigh[`FWCS_BIT_SUSPEND_REQUEST] &&
                !errReg_ff[`FWCS_BIT_ERR] && (busy_ff == 4'h0)) begin // R16 R17
              if (nxt_kind[0] && !opProtOk) begin
                errReg_ff[`FWCS_BIT_SEQUENCE_ERROR_FLAG] <= 1'b1; // R13
                errReg_ff[`FWCS_BIT_ERR] <= 1'b1;
              end else if ((!nxt_kind[0] && nxt_ctrlHigh[`FWCS_BIT_MODULE_SELECT] && opTestSector) ||
                  (opBanks == 4'h0)) begin
                errReg_ff[`FWCS_BIT_WPROT] <= 1'b1; // R15
                errReg_ff[`FWCS_BIT_ERR] <= 1'b1;
              end else begin
                busy_ff <= opBanks; // R1 R2 R3
                heldBanks_ff <= opBanks;
                lock_ff <= 1'b1; // R7
                startBit_ff <= 1'b1; // R16
                opStart_ff <= 1'b1;
              end
            end
          end
        end else if (!lock_ff) begin // R6
          case (busAddr)
            `FWCS_ADDR_EVEN_LOW: begin
              dataWord_ff[0] <= mergeBytes(dataWord_ff[0], busWrData, busByteEn);
            end
            `FWCS_ADDR_EVEN_HIGH: begin
              dataWord_ff[1] <= mergeBytes(dataWord_ff[1], busWrData, busByteEn);
            end
            `FWCS_ADDR_ODD_LOW: begin
              dataWord_ff[2] <= mergeBytes(dataWord_ff[2], busWrData, busByteEn);
            end
            `FWCS_ADDR_ODD_HIGH: begin
              dataWord_ff[3] <= mergeBytes(dataWord_ff[3], busWrData, busByteEn);
            end
            `FWCS_ADDR_PROG_LOW: addrLow_ff <= mergeBytes(addrLow_ff, busWrData, busByteEn);
            `FWCS_ADDR_PROG_HIGH: addrHigh_ff <= mergeBytes(addrHigh_ff, busWrData, busByteEn);
            `FWCS_ADDR_ERROR: errReg_ff <= mergeBytes(errReg_ff, busWrData, busByteEn);
            default: addrLow_ff <= addrLow_ff;
          endcase
        end
      end
    end
  end
endmodule // fwcs_flash_write_ctrl

// ==== verification/fwcs_pe_model.sv ====
// Behavioural program and erase controller that answers starts, resumes and suspends.
`timescale 1ns/1ps
module fwcs_pe_model (
  input wire sys_clk,
  input wire rst_b,
  input wire opStart,
  input wire opResume,
  input wire opSuspendReq,
  input wire [7:0] delay,
  output reg opDone,
  output reg opSuspended,
  output wire [15:0] opErrBits
);
  reg run_ff;
  reg [7:0] cnt_ff;
  assign opErrBits = 16'h0000;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_ff <= 1'b0;
      cnt_ff <= 8'h00;
      opDone <= 1'b0;
      opSuspended <= 1'b0;
    end else begin
      opDone <= 1'b0;
      opSuspended <= 1'b0;
      if (opStart || opResume) begin
        run_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (run_ff && opSuspendReq) begin
        run_ff <= 1'b0;
        opSuspended <= 1'b1;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
        if (cnt_ff == 8'h00) begin
          run_ff <= 1'b0;
          opDone <= 1'b1;
        end
      end
    end
  end
endmodule // fwcs_pe_model

// ==== verification/fwcs_flash_write_ctrl_chk.sv ====
// Concurrent checks on the ports of the flash write control block.
`timescale 1ns/1ps
module fwcs_flash_write_ctrl_chk (
  input wire sys_clk,
  input wire rst_b,
  input wire [23:0] busAddr,
  input wire busRdEn,
  input wire busWrEn,
  input wire [15:0] busWrData,
  input wire [15:0] busRdData_ff,
  input wire busRdValid_ff,
  input wire busTrap_ff,
  input wire [15:0] busTrapCode,
  input wire memRdEn,
  input wire memRdInvalid_ff,
  input wire opStart_ff,
  input wire opResume_ff,
  input wire [3:0] opKind_ff,
  input wire opModule_ff,
  input wire [23:0] opAddr,
  input wire opDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (busRdEn |=> busRdValid_ff)
    else $error("read not answered");
  a_valid_cause: assert property (busRdValid_ff |-> $past(busRdEn))
    else $error("read valid without read");
  a_trap_data: assert property (busRdValid_ff && busTrap_ff && !memRdInvalid_ff |->
    busRdData_ff == 16'hFFFF && busTrapCode == 16'h009B)
    else $error("trapped read not invalid");
  a_start_cause: assert property (opStart_ff |->
    $past(busWrEn && busAddr == 24'h0E0002 && busWrData[15]))
    else $error("start without start write");
  a_start_module: assert property (opStart_ff |-> opModule_ff == $past(busWrData[7]))
    else $error("module select wrong");
  a_prot_range: assert property (opStart_ff && opKind_ff[0] |->
    opAddr >= 24'h0EDFB0 && opAddr <= 24'h0EDFBF)
    else $error("protection start out of range");
  a_done_clear: assert property (opDone |=> opKind_ff == 4'h0 && !opModule_ff)
    else $error("selects not cleared");
  a_inv_cause: assert property (memRdInvalid_ff |-> $past(memRdEn) && busTrap_ff)
    else $error("invalid array read without trap");
  a_resume_cause: assert property (opResume_ff |-> $past(busWrEn && busWrData[15]))
    else $error("resume without start write");
endmodule // fwcs_flash_write_ctrl_chk

// ==== verification/test_flash_write_control_status.sv ====
// Self-checking bench for the flash write control and status block.
`timescale 1ns/1ps
`include "fwcs_defines.vh"
module test_flash_write_control_status;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [23:0] busAddr = 24'h000000;
  reg [23:0] memAddr = 24'h000000;
  reg busRdEn = 1'b0;
  reg busWrEn = 1'b0;
  reg memRdEn = 1'b0;
  reg memWrEn = 1'b0;
  reg bootstrapMode = 1'b0;
  reg [15:0] busWrData = 16'h0000;
  reg [7:0] delay = 8'h40;
  reg [23:0] a;
  reg [15:0] evenWord;
  wire [63:0] opData;
  wire [15:0] busRdData, busTrapCode, opErrBits;
  wire busRdValid, busTrap, memWrBlock, memRdInvalid, opStart, opResume, opSusp;
  wire opDone, opSuspended;
  logic [16:0] expQ[$];
  int failures = 0;
  int check_count = 0;
  int i, k;
  fwcs_flash_write_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .busAddr(busAddr),
    .busRdEn(busRdEn), .busWrEn(busWrEn), .busByteEn(2'h3), .busWrData(busWrData),
    .busRdData_ff(busRdData), .busRdValid_ff(busRdValid), .busTrap_ff(busTrap),
    .busTrapCode(busTrapCode), .bootstrapMode(bootstrapMode), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrBlock(memWrBlock),
    .memRdInvalid_ff(memRdInvalid), .opStart_ff(opStart), .opResume_ff(opResume),
    .opSuspendReq_ff(opSusp), .opKind_ff(), .opModule_ff(), .opAddr(), .opData(opData),
    .opDone(opDone), .opSuspended(opSuspended), .opErrBits(opErrBits));
  fwcs_pe_model pe (.sys_clk(sys_clk), .rst_b(rst_b), .opStart(opStart),
    .opResume(opResume), .opSuspendReq(opSusp), .delay(delay), .opDone(opDone),
    .opSuspended(opSuspended), .opErrBits(opErrBits));
  always #20 sys_clk = ~sys_clk;
  task chk(input string n, input [16:0] s, input [16:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    chk("pending", 17'(expQ.size()), 17'h0);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task bus(input w, input [23:0] ad, input [15:0] d, input [16:0] e);
    busAddr = ad;
    busWrData = d;
    busWrEn = w;
    busRdEn = !w;
    if (!w) expQ.push_back(e);
    @(posedge sys_clk);
    #1 busWrEn = 1'b0;
    busRdEn = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  always @(negedge sys_clk) begin
    if (busRdValid === 1'b1) chk("read", {busTrap, busRdData}, expQ.pop_front());
  end
  task mem(input [23:0] ad, input eb, input ei);
    memAddr = ad;
    memRdEn = 1'b1;
    memWrEn = 1'b1;
    #1 if (eb !== 1'bx) chk("wrblock", memWrBlock, eb);
    @(posedge sys_clk);
    #1 memRdEn = 1'b0;
    memWrEn = 1'b0;
    chk("rdinvalid", memRdInvalid, ei);
    @(posedge sys_clk);
    #1;
  endtask
  task start(input [23:0] ad, input [15:0] hi, input [15:0] st);
    bus(1'b1, `FWCS_ADDR_PROG_LOW, ad[15:0], 17'h0);
    bus(1'b1, `FWCS_ADDR_PROG_HIGH, {8'h00, ad[23:16]}, 17'h0);
    evenWord = 16'($urandom);
    bus(1'b1, `FWCS_ADDR_EVEN_LOW, evenWord, 17'h0);
    chk("evendata", opData[15:0], evenWord);
    bus(1'b1, `FWCS_ADDR_CTRL_HIGH, hi, 17'h0);
    bus(1'b0, `FWCS_ADDR_CTRL_LOW, 16'h0, {1'b0, st});
    if (st != 16'h0) bus(1'b0, `FWCS_ADDR_CTRL_HIGH, 16'h0, 17'h1FFFF);
  endtask
  task finish;
    i = 0;
    while (opDone !== 1'b1 && opSuspended !== 1'b1 && i < 400) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    if (i >= 400) failures++;
    @(posedge sys_clk);
    #1;
  endtask
  task ended;
    finish;
    bus(1'b0, `FWCS_ADDR_CTRL_LOW, 16'h0, 17'h0);
    bus(1'b0, `FWCS_ADDR_CTRL_HIGH, 16'h0, 17'h0);
    bus(1'b0, `FWCS_ADDR_ERROR, 16'h0, 17'h0);
  endtask
  initial begin
    i = $urandom(32'h6B14);
    repeat (20) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    @(posedge sys_clk);
    #1;
    bus(1'b0, `FWCS_ADDR_CTRL_HIGH, 16'h0, 17'h0);
    bus(1'b1, `FWCS_ADDR_CTRL_LOW, 16'hFFFF, 17'h0);
    bus(1'b0, `FWCS_ADDR_CTRL_LOW, 16'h0, 17'h0);
    bus(1'b0, 24'h0E0020, 16'h0, 17'h0);
    for (k = 0; k < 4; k++) begin
      case (k)
        0: a = 24'h010000;
        1: a = `FWCS_BANK1_BASE;
        2: a = `FWCS_BANK2_BASE;
        default: a = `FWCS_BANK3_BASE;
      endcase
      a = a + 24'($urandom % 32'h20000);
      delay = 8'(40 + $urandom % 64);
      start(a, k < 2 ? 16'hA080 : 16'hA000, 16'h0010 | 16'(1 << (k < 2 ? k + 5 : k - 1)));
      mem(a, 1'b1, 1'b1);
      mem(k[0] ? 24'h010000 : `FWCS_BANK1_BASE, 1'b0, 1'b0);
      ended;
    end
    for (k = 0; k < 4; k++) begin
      a = k[1] ? (k[0] ? 24'h0EDFC0 : 24'h0EDFAF) : (k[0] ? 24'h0EDFBF : 24'h0EDFB0);
      start(a, 16'h8100, k[1] ? 16'h0000 : 16'h0012);
      if (!k[1]) ended;
      else begin
        bus(1'b0, `FWCS_ADDR_ERROR, 16'h0, 17'h00003);
        bus(1'b1, `FWCS_ADDR_ERROR, 16'h0, 17'h0);
        bus(1'b1, `FWCS_ADDR_CTRL_HIGH, 16'h0, 17'h0);
      end
    end
    start(24'h001000, 16'hA080, 16'h0000);
    bus(1'b0, `FWCS_ADDR_ERROR, 16'h0, 17'h00005);
    bus(1'b1, `FWCS_ADDR_ERROR, 16'h0, 17'h0);
    bus(1'b1, `FWCS_ADDR_CTRL_HIGH, 16'h0, 17'h0);
    delay = 8'hC8;
    start(24'h030000, 16'h8880, 16'h0030);
    bus(1'b1, `FWCS_ADDR_CTRL_HIGH, 16'h4000, 17'h0);
    finish;
    bus(1'b0, `FWCS_ADDR_CTRL_LOW, 16'h0, 17'h0);
    bus(1'b0, `FWCS_ADDR_CTRL_HIGH, 16'h0, 17'h04880);
    mem(24'h030000, 1'b0, 1'b0);
    bus(1'b1, `FWCS_ADDR_CTRL_HIGH, 16'h8880, 17'h0);
    bus(1'b0, `FWCS_ADDR_CTRL_LOW, 16'h0, 17'h00030);
    ended;
    mem(24'h001000, 1'bx, 1'b1);
    bootstrapMode = 1'b1;
    mem(24'h001000, 1'bx, 1'b0);
    conclude;
  end
  initial begin
    #(40 * 30000);
    failures++;
    conclude;
  end
endmodule // test_flash_write_control_status
bind fwcs_flash_write_ctrl fwcs_flash_write_ctrl_chk chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .busAddr(busAddr), .busRdEn(busRdEn), .busWrEn(busWrEn), .busWrData(busWrData),
  .busRdData_ff(busRdData_ff), .busRdValid_ff(busRdValid_ff), .busTrap_ff(busTrap_ff),
  .busTrapCode(busTrapCode), .memRdEn(memRdEn), .memRdInvalid_ff(memRdInvalid_ff),
  .opStart_ff(opStart_ff), .opResume_ff(opResume_ff), .opKind_ff(opKind_ff),
  .opModule_ff(opModule_ff), .opAddr(opAddr), .opDone(opDone));
